// [inc/pmx_pkg.sv]
package pmx_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] PMX_IDX_P3DATA = 8'hE3;
  localparam logic [7:0] PMX_IDX_P2PEND = 8'hE6;
  localparam logic [7:0] PMX_IDX_P2PULL = 8'hEE;
  localparam logic [7:0] PMX_IDX_P3CTRL = 8'hEF;
  localparam logic [7:0] PMX_IDX_IMASK  = 8'hF8;

  // Reset values
  localparam logic [7:0] PMX_RST_P3DATA = 8'h00;
  localparam logic [7:0] PMX_RST_P2PEND = 8'h00;
  localparam logic [7:0] PMX_RST_P2PULL = 8'h00;
  localparam logic [7:0] PMX_RST_P3CTRL = 8'h00;
  localparam logic [7:0] PMX_RST_IMASK  = 8'h00;

  // Port-3 control fields
  localparam int PMX_CON_PKG_HI   = 7;
  localparam int PMX_CON_PKG_LO   = 6;
  localparam int PMX_CON_ALT1     = 5;
  localparam int PMX_CON_MODE1_HI = 4;
  localparam int PMX_CON_MODE1_LO = 3;
  localparam int PMX_CON_ALT0     = 2;
  localparam int PMX_CON_MODE0_HI = 1;
  localparam int PMX_CON_MODE0_LO = 0;

  // Port-3 data fields
  localparam int PMX_DAT_CARRIER = 7;
  localparam int PMX_DAT_UNUSED  = 6;

  // Package mapping code for the small package
  localparam logic [1:0] PMX_PKG_SMALL = 2'h0;

  // Pin modes
  typedef enum logic [1:0] {
    PMX_MODE_IN    = 2'b00,
    PMX_MODE_OD    = 2'b01,
    PMX_MODE_PP    = 2'b10,
    PMX_MODE_IN_PU = 2'b11
  } pmx_mode_t;

endpackage

// [logic/pmx_pin_drv.sv]
`timescale 1ns/1ns
module pmx_pin_drv
  import pmx_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic reset_in,
  // Control
  input  wire logic [1:0] mode_in,
  input  wire logic       value_in,
  // Pin
  output logic            pin_out,
  output logic            pin_oe_out,
  output logic            pin_pullup_out
);

  pmx_mode_t mode;
  assign mode = pmx_mode_t'(mode_in);

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_out        <= 1'b0;
      pin_oe_out     <= 1'b0;
      pin_pullup_out <= 1'b0;
    end else begin
      case (mode)
        PMX_MODE_OD: begin
          // Open drain only ever drives low
          pin_out        <= 1'b0;
          pin_oe_out     <= ~value_in;
          pin_pullup_out <= 1'b0;
        end
        PMX_MODE_PP: begin
          pin_out        <= value_in;
          pin_oe_out     <= 1'b1;
          pin_pullup_out <= 1'b0;
        end
        PMX_MODE_IN_PU: begin
          pin_out        <= 1'b0;
          pin_oe_out     <= 1'b0;
          pin_pullup_out <= 1'b1;
        end
        default: begin
          pin_out        <= 1'b0;
          pin_oe_out     <= 1'b0;
          pin_pullup_out <= 1'b0;
        end
      endcase
    end
  end

endmodule // pmx_pin_drv

// [logic/pmx_edge_det.sv]
`timescale 1ns/1ns
module pmx_edge_det #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  // Levels and events
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] fall_out
);

  logic [WIDTH-1:0] prev_r;

  // Falling edge per pin; one-cycle pulse
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
        prev_r[i]   <= 1'b1;
        fall_out[i] <= 1'b0;
      end else begin
        prev_r[i]   <= level_in[i];
        fall_out[i] <= prev_r[i] & ~level_in[i];
      end
    end
  end

endmodule // pmx_edge_det

// [logic/pmx_top.sv]
`timescale 1ns/1ns
// Contract
// R1 - Writing zero to a port-2 pending bit clears that pending flag.
// R2 - Writing one to a port-2 pending bit leaves it unchanged.
// R3 - Control 7:6 zero: small mapping, pin 0 PWM and captures, pin 1 remote/clock.
// R4 - Other 7:6 values: pin 0 PWM/capture, pin 3 captures, pin 1 remote, pin 2 clock.
// R5 - Control bit 5 selects pin 1 normal I/O or remote/clock functions.
// R6 - Control 4:3 set pin 1 mode: input, open drain, push-pull, input pull-up.
// R7 - Control bit 2 enables pin 0 PWM/capture and pin 3 capture functions.
// R8 - Control 1:0 set pin 0 mode: input, open drain, push-pull, input pull-up.
// R9 - Data register bit 7 turns the carrier on or off.
// R10 - Data register bit 6 has no function; seven bits are meaningful.
// R11 - Data bits 1 and 0 map to port-3 pins 1 and 0.
// R12 - Pins 3 and 2 are inputs only, pull-up always on; the code holds it off during reset until the first clock after release.
// R13 - Pins 5 and 4 are not configured by the port-3 control register.
// R14 - Only control bits 5 and 2 enable alternative functions.
// R15 - Large mapping: pin 0 capture if 1:0 equal, PWM if differ.
// R16 - Large mapping: pin 2 clock, pin 1 remote if 4:3 differ.
// R17 - Port-2 pull-up enable bit n drives pin n pull-up, reset zero.
module pmx_top
  import pmx_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              reset_in,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // Interrupt
  output logic                   irq_out,
  // Port 2
  input  wire logic [7:0]        port2_pins_in,
  output logic      [7:0]        port2_pullup_enables_out,
  // Port 3 pins 0 and 1
  input  wire logic              port3_pin_zero_in,
  output logic                   port3_pin_zero_out,
  output logic                   port3_pin_zero_oe_out,
  output logic                   port3_pin_zero_pullup_out,
  input  wire logic              port3_pin_one_in,
  output logic                   port3_pin_one_out,
  output logic                   port3_pin_one_oe_out,
  output logic                   port3_pin_one_pullup_out,
  // Port 3 pins 2 and 3, input only
  input  wire logic              port3_pin_two_in,
  input  wire logic              port3_pin_three_in,
  output logic                   port3_pin_two_pullup_out,
  output logic                   port3_pin_three_pullup_out,
  // Timer and carrier side
  input  wire logic              timer0_pwm_output_in,
  input  wire logic              remote_carrier_in,
  output logic                   timer0_capture_input_out,
  output logic                   timer1_capture_input_out,
  output logic                   timer2_capture_input_out,
  output logic                   timer0_external_clock_out
);

  // Registers
  logic [7:0] port3_pin_control_r;
  logic [7:0] port2_pullup_enables_r;
  logic [7:0] port2_irq_pending_flags_r;
  logic [7:0] port2_irq_pending_flags_nxt;
  logic [7:0] port3_data_register_r;
  logic [7:0] irq_mask_r;
  logic       wait_r;
  logic [31:0] rdata_r;

  // Bus decode
  logic [7:0] idx;
  logic       req;
  logic       wr_go;
  logic       lane0;
  logic       hit_con;
  logic       hit_pur;
  logic       hit_pend;
  logic       hit_data;
  logic       hit_mask;
  logic       addr_ok;
  logic [7:0] rd_mux;

  // Pin decode
  logic       pkg_small;
  logic       alt0_en;
  logic       alt1_en;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic       pin0_pwm;
  logic       pin0_cap;
  logic       pin1_remote;
  logic       pin1_clk;
  logic       pin2_clk;
  logic       pin3_cap;
  logic       pin0_val;
  logic       pin1_val;
  logic       carrier_gated;
  logic [7:0] p2_fall;

  assign idx   = avs_address_in[9:2];
  assign req   = avs_read_in | avs_write_in;
  // Access completes on the cycle waitrequest is low
  assign wr_go = avs_write_in & ~wait_r;
  assign lane0 = avs_byteenable_in[0];

  assign hit_con  = (idx == PMX_IDX_P3CTRL);
  assign hit_pur  = (idx == PMX_IDX_P2PULL);
  assign hit_pend = (idx == PMX_IDX_P2PEND);
  assign hit_data = (idx == PMX_IDX_P3DATA);
  assign hit_mask = (idx == PMX_IDX_IMASK);
  assign addr_ok  = (avs_address_in[1:0] == 2'h0);

  // Read mux; unmapped or misaligned reads return zero
  always_comb begin
    rd_mux = 8'h00;
    if (addr_ok) begin
      if (hit_con) begin
        rd_mux = port3_pin_control_r;
      end else if (hit_pur) begin
        rd_mux = port2_pullup_enables_r;
      end else if (hit_pend) begin
        rd_mux = port2_irq_pending_flags_r;
      end else if (hit_mask) begin
        rd_mux = irq_mask_r;
      end else if (hit_data) begin
        rd_mux = port3_data_register_r;
        rd_mux[PMX_DAT_UNUSED] = 1'b0; // R10
        // Low nibble shows pin levels
        rd_mux[3:0] = {port3_pin_three_in, port3_pin_two_in,
                       port3_pin_one_in, port3_pin_zero_in}; // R11
      end
    end
  end

  // Fixed one wait state: drop waitrequest for one cycle per access
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      wait_r <= 1'b1;
    end else if (req & wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read_in & wait_r) begin
      rdata_r <= {24'h00_0000, rd_mux};
    end
  end

  assign avs_readdata_out    = rdata_r;
  assign avs_waitrequest_out = wait_r;

  // Control register
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      port3_pin_control_r <= PMX_RST_P3CTRL;
    end else if (wr_go & lane0 & addr_ok & hit_con) begin
      port3_pin_control_r <= avs_writedata_in[7:0];
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      port2_pullup_enables_r <= PMX_RST_P2PULL; // R17
    end else if (wr_go & lane0 & addr_ok & hit_pur) begin
      port2_pullup_enables_r <= avs_writedata_in[7:0]; // R17
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      port3_data_register_r <= PMX_RST_P3DATA;
    end else if (wr_go & lane0 & addr_ok & hit_data) begin
      port3_data_register_r <= avs_writedata_in[7:0];
      port3_data_register_r[PMX_DAT_UNUSED] <= 1'b0; // R10
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_mask_r <= PMX_RST_IMASK;
    end else if (wr_go & lane0 & addr_ok & hit_mask) begin
      irq_mask_r <= avs_writedata_in[7:0];
    end
  end

  // Port-2 edge events
  pmx_edge_det #(
    .WIDTH (8)
  ) u_p2_edge (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .level_in (port2_pins_in),
    .fall_out (p2_fall)
  );

  // Pending flags: zero clears, one keeps, new edge wins over clear
  always_comb begin
    port2_irq_pending_flags_nxt = port2_irq_pending_flags_r;
    if (wr_go & lane0 & addr_ok & hit_pend) begin
      port2_irq_pending_flags_nxt = port2_irq_pending_flags_r
                                    & avs_writedata_in[7:0]; // R1 R2
    end
    port2_irq_pending_flags_nxt = port2_irq_pending_flags_nxt | p2_fall;
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      port2_irq_pending_flags_r <= PMX_RST_P2PEND;
    end else begin
      port2_irq_pending_flags_r <= port2_irq_pending_flags_nxt;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(port2_irq_pending_flags_nxt & irq_mask_r);
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      port2_pullup_enables_out <= PMX_RST_P2PULL;
    end else begin
      port2_pullup_enables_out <= port2_pullup_enables_r; // R17
    end
  end

  // Function decode
  assign pkg_small = (port3_pin_control_r[PMX_CON_PKG_HI:PMX_CON_PKG_LO]
                      == PMX_PKG_SMALL); // R3 R4
  // Only bits 5 and 2 switch alternative functions
  assign alt0_en = port3_pin_control_r[PMX_CON_ALT0]; // R7 R14
  assign alt1_en = port3_pin_control_r[PMX_CON_ALT1]; // R5 R14
  assign mode0   = port3_pin_control_r[PMX_CON_MODE0_HI:PMX_CON_MODE0_LO]; // R8
  assign mode1   = port3_pin_control_r[PMX_CON_MODE1_HI:PMX_CON_MODE1_LO]; // R6

  // Equal mode bits mean an input role, differing bits an output role
  assign pin0_pwm = alt0_en & (mode0[1] ^ mode0[0]); // R15
  assign pin0_cap = alt0_en & ~(mode0[1] ^ mode0[0]); // R15
  assign pin1_remote = alt1_en & (mode1[1] ^ mode1[0]); // R16
  // Small package shares pin 1 for the timer clock
  assign pin1_clk = alt1_en & pkg_small & ~(mode1[1] ^ mode1[0]); // R3
  assign pin2_clk = alt1_en & ~pkg_small; // R4 R16
  assign pin3_cap = alt0_en & ~pkg_small; // R4 R7

  assign carrier_gated = remote_carrier_in
                         & port3_data_register_r[PMX_DAT_CARRIER]; // R9

  assign pin0_val = pin0_pwm ? timer0_pwm_output_in
                             : port3_data_register_r[0]; // R11
  assign pin1_val = pin1_remote ? carrier_gated
                             : port3_data_register_r[1]; // R11

  // Pin drivers; modes apply whatever function is chosen
  pmx_pin_drv u_pin0 (
    .mclk_in        (mclk_in),
    .reset_in       (reset_in),
    .mode_in        (mode0), // R8
    .value_in       (pin0_val),
    .pin_out        (port3_pin_zero_out),
    .pin_oe_out     (port3_pin_zero_oe_out),
    .pin_pullup_out (port3_pin_zero_pullup_out)
  );

  pmx_pin_drv u_pin1 (
    .mclk_in        (mclk_in),
    .reset_in       (reset_in),
    .mode_in        (mode1), // R6
    .value_in       (pin1_val),
    .pin_out        (port3_pin_one_out),
    .pin_oe_out     (port3_pin_one_oe_out),
    .pin_pullup_out (port3_pin_one_pullup_out)
  );

  // Pins 2 and 3 have no mode field; pull-up follows reset release.
  // Pins 4 and 5 belong to the upper control register, not here.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      port3_pin_two_pullup_out   <= 1'b0;
      port3_pin_three_pullup_out <= 1'b0;
    end else begin
      port3_pin_two_pullup_out   <= 1'b1; // R12 R13
      port3_pin_three_pullup_out <= 1'b1; // R12
    end
  end

  // Timer inputs; idle low when the function is off
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      timer0_capture_input_out <= 1'b0;
    end else begin
      timer0_capture_input_out <= pin0_cap & port3_pin_zero_in; // R15
    end
  end

  // Small package folds all captures onto pin 0
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      timer1_capture_input_out <= 1'b0;
      timer2_capture_input_out <= 1'b0;
    end else if (pkg_small) begin
      timer1_capture_input_out <= pin0_cap & port3_pin_zero_in; // R3
      timer2_capture_input_out <= pin0_cap & port3_pin_zero_in; // R3
    end else begin
      timer1_capture_input_out <= pin3_cap & port3_pin_three_in; // R4 R15
      timer2_capture_input_out <= pin3_cap & port3_pin_three_in; // R4
    end
  end

  // Clock pin moves with the package; raw level, no glitch filter
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      timer0_external_clock_out <= 1'b0;
    end else if (pkg_small) begin
      timer0_external_clock_out <= pin1_clk & port3_pin_one_in; // R3
    end else begin
      timer0_external_clock_out <= pin2_clk & port3_pin_two_in; // R16
    end
  end

endmodule // pmx_top

// [dv/pmx_top_properties.sv]
`timescale 1ns/1ns
module pmx_top_properties
  import pmx_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  // Clock, reset, bus
  input wire logic              mclk_in,
  input wire logic              reset_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic              avs_read_in,
  input wire logic              avs_write_in,
  input wire logic [31:0]       avs_writedata_in,
  input wire logic [3:0]        avs_byteenable_in,
  input wire logic              avs_waitrequest_out,
  // Interrupt and port 2
  input wire logic              irq_out,
  input wire logic [7:0]        port2_pins_in,
  input wire logic [7:0]        port2_pullup_enables_out,
  // Port 3 and timers
  input wire logic              port3_pin_zero_out,
  input wire logic              port3_pin_zero_oe_out,
  input wire logic              port3_pin_zero_pullup_out,
  input wire logic              port3_pin_one_out,
  input wire logic              port3_pin_one_oe_out,
  input wire logic              port3_pin_one_pullup_out,
  input wire logic              port3_pin_two_pullup_out,
  input wire logic              port3_pin_three_pullup_out,
  input wire logic              timer0_capture_input_out,
  input wire logic              timer1_capture_input_out,
  input wire logic              timer2_capture_input_out,
  input wire logic              timer0_external_clock_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic       wr_ok, fall_w, a0_r, a1_r;
  logic [7:0] con_r, dat_r, pu_r, p2_r;
  logic [2:0] e0_r, e1_r;
  function automatic logic [2:0] exp_pin(input logic [1:0] m, input logic v);
    case (m)
      PMX_MODE_OD:    return {~v, 2'b00};
      PMX_MODE_PP:    return {1'b1, v, 1'b0};
      PMX_MODE_IN_PU: return 3'b001;
      default:        return 3'b000;
    endcase
  endfunction
  assign wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  assign fall_w = |(p2_r & ~port2_pins_in);
  // Shadow registers, updated at the same edge as the device
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      con_r <= PMX_RST_P3CTRL;
      dat_r <= PMX_RST_P3DATA;
      pu_r <= PMX_RST_P2PULL;
    end else if (wr_ok) begin
      case (avs_address_in)
        ADDR_W'({PMX_IDX_P3CTRL, 2'b00}): con_r <= avs_writedata_in[7:0];
        ADDR_W'({PMX_IDX_P3DATA, 2'b00}): dat_r <= avs_writedata_in[7:0];
        ADDR_W'({PMX_IDX_P2PULL, 2'b00}): pu_r <= avs_writedata_in[7:0];
        default: ;
      endcase
    end
  end
  // One edge of lag, as the pin drivers have
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      p2_r <= 8'hff;
      e0_r <= 3'b000;
      e1_r <= 3'b000;
      a0_r <= 1'b0;
      a1_r <= 1'b0;
    end else begin
      p2_r <= port2_pins_in;
      e0_r <= exp_pin(con_r[1:0], dat_r[0]);
      e1_r <= exp_pin(con_r[4:3], dat_r[1]);
      a0_r <= con_r[PMX_CON_ALT0];
      a1_r <= con_r[PMX_CON_ALT1];
    end
  end
  a_wait_one_low: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  a_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("request not answered");
  a_pullup_copy: assert property (port2_pullup_enables_out == $past(pu_r))
    else $error("port-2 pull-ups differ from register");
  a_pin0_mode: assert property (!a0_r |-> {port3_pin_zero_oe_out, port3_pin_zero_out,
    port3_pin_zero_pullup_out} == e0_r) else $error("pin 0 drive wrong");
  a_pin1_mode: assert property (!a1_r |-> {port3_pin_one_oe_out, port3_pin_one_out,
    port3_pin_one_pullup_out} == e1_r) else $error("pin 1 drive wrong");
  a_capture_off: assert property (!a0_r && !$past(a0_r) |-> !(timer0_capture_input_out
    || timer1_capture_input_out || timer2_capture_input_out)) else $error("capture while off");
  a_clock_off: assert property (!a1_r && !$past(a1_r) |-> !timer0_external_clock_out)
    else $error("timer clock while off");
  a_input_pullups: assert property ($past(!reset_in) |-> port3_pin_two_pullup_out
    && port3_pin_three_pullup_out) else $error("pins 2 and 3 lost pull-up");
  a_irq_cause: assert property ($rose(irq_out) |-> $past(fall_w, 1) || $past(fall_w, 2)
    || $past(fall_w, 3) || $past(wr_ok, 1) || $past(wr_ok, 2)) else $error("irq without cause");
  a_irq_drop: assert property ($fell(irq_out) |-> $past(wr_ok, 1) || $past(wr_ok, 2))
    else $error("irq fell without a write");
endmodule // pmx_top_properties

bind pmx_top pmx_top_properties #(.ADDR_W(ADDR_W)) u_props (.mclk_in, .reset_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
  .avs_waitrequest_out, .irq_out, .port2_pins_in, .port2_pullup_enables_out,
  .port3_pin_zero_out, .port3_pin_zero_oe_out, .port3_pin_zero_pullup_out,
  .port3_pin_one_out, .port3_pin_one_oe_out, .port3_pin_one_pullup_out,
  .port3_pin_two_pullup_out, .port3_pin_three_pullup_out, .timer0_capture_input_out,
  .timer1_capture_input_out, .timer2_capture_input_out, .timer0_external_clock_out);

// [dv/pmx_pin_env.sv]
`timescale 1ns/1ns
module pmx_pin_env
  import pmx_pkg::*;
(
  // Clock and bench drive
  input  wire logic       mclk_in,
  input  wire logic [7:0] p2_val_in,
  input  wire logic [7:0] p2_en_in,
  input  wire logic [3:0] ext_val_in,
  input  wire logic [3:0] ext_en_in,
  // Device side
  input  wire logic [7:0] p2_pu_in,
  input  wire logic [3:0] drv_in,
  input  wire logic [3:0] drv_oe_in,
  input  wire logic [3:0] pu_in,
  // Pin levels
  output logic      [7:0] p2_lvl_out,
  output logic      [3:0] port3_lvl_out
);
  // Floating pins wander so a stale level never passes for a real one
  logic flip_r = 1'b0;
  always @(posedge mclk_in) flip_r <= ~flip_r;
  assign p2_lvl_out = (p2_en_in & p2_val_in) | (~p2_en_in & (p2_pu_in | {8{flip_r}}));
  // Device drive wins over the external source
  assign port3_lvl_out = (drv_oe_in & drv_in) | (~drv_oe_in & ((ext_en_in & ext_val_in)
    | (~ext_en_in & (pu_in | {4{flip_r}}))));
endmodule // pmx_pin_env

// [dv/pmx_top_tb_top.sv]
`timescale 1ns/1ns
module pmx_top_tb_top
  import pmx_pkg::*;
;
  logic        mclk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        rd = 1'b0, wr = 1'b0, pwm = 1'b0, car = 1'b0;
  logic [9:0]  addr = 10'h000;
  logic [31:0] wd = 32'h0000_0000, rdata, seed = 32'hc3e4_7728;
  logic [3:0]  be = 4'h1, ext = 4'h0, exe = 4'hf, lvl;
  logic [7:0]  p2v = 8'hff, p2l, pu2, v, r;
  logic        wreq, irq, o0, oe0, pu0, o1, oe1, pu1, pu2p, pu3p, c0, c1, c2, tck, pw;
  logic [9:0]  x;
  int          failures = 0, check_count = 0, cyc = 0;
  logic [7:0]  cfg [8] = '{8'h04, 8'h07, 8'h44, 8'h45, 8'hc7, 8'h70, 8'h38, 8'h30};
  always #10 mclk_in = ~mclk_in;
  pmx_top uut (.mclk_in, .reset_in, .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .irq_out(irq),
    .port2_pins_in(p2l), .port2_pullup_enables_out(pu2), .port3_pin_zero_in(lvl[0]),
    .port3_pin_zero_out(o0), .port3_pin_zero_oe_out(oe0), .port3_pin_zero_pullup_out(pu0),
    .port3_pin_one_in(lvl[1]), .port3_pin_one_out(o1), .port3_pin_one_oe_out(oe1),
    .port3_pin_one_pullup_out(pu1), .port3_pin_two_in(lvl[2]), .port3_pin_three_in(lvl[3]),
    .port3_pin_two_pullup_out(pu2p), .port3_pin_three_pullup_out(pu3p),
    .timer0_pwm_output_in(pwm), .remote_carrier_in(car), .timer0_capture_input_out(c0),
    .timer1_capture_input_out(c1), .timer2_capture_input_out(c2),
    .timer0_external_clock_out(tck));
  pmx_pin_env u_env (.mclk_in, .p2_val_in(p2v), .p2_en_in(8'hff), .ext_val_in(ext),
    .ext_en_in(exe), .p2_pu_in(pu2), .drv_in({2'b00, o1, o0}), .drv_oe_in({2'b00, oe1, oe0}),
    .pu_in({pu3p, pu2p, pu1, pu0}), .p2_lvl_out(p2l), .port3_lvl_out(lvl));
  task automatic stop_test;
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
    int n = 0;
    @(posedge mclk_in);
    addr <= {idx, 2'b00};
    rd <= !w;
    wr <= w;
    wd <= {24'h00_0000, d};
    do begin
      @(posedge mclk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) chk("waitrequest", 0, 1);
  endtask
  function automatic logic [2:0] pin_exp(input logic [1:0] m, input logic d);
    return m == 2'b10 ? {1'b1, d, 1'b0} :
           m == 2'b01 ? {~d, 2'b00} : {2'b00, m == 2'b11};
  endfunction
  // Mask picks the outputs that the mapping defines, except timer 2 capture in the large mapping
  function automatic logic [9:0] alt_exp(input logic [7:0] c, input logic [3:0] e,
                                         input logic k);
    logic cap, rmt;
    cap = c[2] && (c[1] == c[0]);
    rmt = c[5] && (c[4] != c[3]);
    if (c[7:6] == PMX_PKG_SMALL) return {5'b11111, {3{cap & e[0]}}, c[5] & !rmt & e[1], rmt & k};
    return {5'b11011, cap & e[0], c[2] & e[3], 1'b0, c[5] & e[2], rmt & k};
  endfunction
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      stop_test;
    end
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    reset_in <= 1'b0;
    bus(0, PMX_IDX_P2PULL, 8'h00, r);
    chk("pullup_reset", PMX_RST_P2PULL, r);
    bus(0, PMX_IDX_P3CTRL, 8'h00, r);
    chk("control_reset", PMX_RST_P3CTRL, r);
    bus(1, 8'h10, 8'hff, r);
    bus(0, 8'h10, 8'h00, r);
    chk("unmapped", 8'h00, r);
    chk("pullups_23", 2'b11, {pu2p, pu3p});
    // A write with lane 0 off must be ignored
    be <= 4'h0;
    bus(1, PMX_IDX_P2PULL, 8'h5a, r);
    be <= 4'h1;
    bus(0, PMX_IDX_P2PULL, 8'h00, r);
    chk("lane_off", PMX_RST_P2PULL, r);
    for (int i = 0; i < 12; i++) begin
      v = 8'($random(seed));
      pwm <= v[2];
      bus(1, PMX_IDX_P2PULL, v, r);
      bus(0, PMX_IDX_P2PULL, 8'h00, r);
      chk("pullup_reg", v, r);
      chk("pullup_out", v, pu2);
      bus(1, PMX_IDX_P3CTRL, v & 8'h1b, r);
      bus(1, PMX_IDX_P3DATA, {v[3:0], v[7:4]}, r);
      repeat (2) @(posedge mclk_in);
      chk("pin0", pin_exp(v[1:0], v[4]), {oe0, o0, pu0});
      chk("pin1", pin_exp(v[4:3], v[5]), {oe1, o1, pu1});
    end
    bus(1, PMX_IDX_P3DATA, 8'hff, r);
    bus(0, PMX_IDX_P3DATA, 8'h00, r);
    chk("data_high", 2'b10, r[7:6]);
    bus(1, PMX_IDX_IMASK, 8'h00, r);
    p2v <= 8'hf7;
    repeat (4) @(posedge mclk_in);
    chk("irq_masked", 1'b0, irq);
    bus(1, PMX_IDX_IMASK, 8'h08, r);
    repeat (2) @(posedge mclk_in);
    chk("irq_set", 1'b1, irq);
    bus(1, PMX_IDX_P2PEND, 8'hff, r);
    bus(0, PMX_IDX_P2PEND, 8'h00, r);
    chk("pending_one", 8'h08, r);
    bus(1, PMX_IDX_P2PEND, 8'hf7, r);
    bus(0, PMX_IDX_P2PEND, 8'h00, r);
    chk("pending_zero", 8'h00, r);
    chk("irq_clear", 1'b0, irq);
    foreach (cfg[j]) begin
      bus(1, PMX_IDX_P3CTRL, cfg[j], r);
      for (int i = 0; i < 4; i++) begin
        v = 8'($random(seed));
        ext <= v[3:0];
        car <= v[4];
        pwm <= v[6];
        bus(1, PMX_IDX_P3DATA, {v[5], 7'h00}, r);
        repeat (3) @(posedge mclk_in);
        x = alt_exp(cfg[j], v[3:0], v[4] & v[5]);
        chk("alt_fn", x[4:0] & x[9:5], {c0, c1, c2, tck, o1} & x[9:5]);
        pw = cfg[j][2] && (cfg[j][1] != cfg[j][0]) && v[6];
        chk("pin0_alt", pin_exp(cfg[j][1:0], pw), {oe0, o0, pu0});
      end
    end
    stop_test;
  end
endmodule // pmx_top_tb_top
